// ==== design/pnr_regmap.sv ====
// Paged host register map of the network controller
`timescale 1ns/100ps
`default_nettype none
module pnr_regmap (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  // Host pins
  input wire logic host_rd_n_i,
  input wire logic host_wr_n_i,
  input wire logic [3:0] register_offset_i,
  input wire logic [7:0] host_data_i,
  output logic [7:0] host_data_o,
  output logic host_data_oe_o,
  // Core status and events
  input wire pnr_pkg::pnr_core_stat_t core_stat_i,
  input wire logic [7:0] int_event_i,
  input wire logic tx_start_i,
  input wire logic local_addr_ld_i,
  input wire logic [15:0] local_addr_i,
  input wire logic page_adv_i,
  // Core controls
  output pnr_pkg::pnr_cfg_t cfg_o,
  output logic local_dma_abort_o,
  output logic loopback_pop_o
);

  // ==========================================================
  // Host pin capture
  localparam int PIN_W = 14;
  logic [PIN_W-1:0] pins_raw;
  logic [PIN_W-1:0] pins_sync;
  logic s_rd_n;
  logic s_wr_n;
  logic [3:0] s_off;
  logic [7:0] s_data;
  logic rd_n_prev_ff;
  logic wr_n_prev_ff;
  logic rd_start;
  logic wr_start;

  assign pins_raw = {host_rd_n_i, host_wr_n_i, register_offset_i,
                     host_data_i};

  pnr_sync #(
    .WIDTH(PIN_W)
  ) u_pin_sync (
    .sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i),
    .async_i(pins_raw),
    .reset_val_i({2'h3, 12'h000}),
    .sync_o(pins_sync)
  );

  assign s_rd_n = pins_sync[13];
  assign s_wr_n = pins_sync[12];
  assign s_off = pins_sync[11:8];
  assign s_data = pins_sync[7:0];

  always_ff @(posedge sys_clk_i)
  begin
    if (!reset_n_i)
    begin
      rd_n_prev_ff <= 1'b1;
      wr_n_prev_ff <= 1'b1;
    end
    else
    begin
      rd_n_prev_ff <= s_rd_n;
      wr_n_prev_ff <= s_wr_n;
    end
  end

  // One access per strobe: acted on at the falling edge only
  assign rd_start = rd_n_prev_ff && !s_rd_n;
  assign wr_start = wr_n_prev_ff && !s_wr_n;

  // ==========================================================
  // Page decode
  logic [7:0] command_ff;
  logic [1:0] page;

  assign page = {command_ff[pnr_pkg::PAGE_SELECT_HI_POS],
                 command_ff[pnr_pkg::PAGE_SELECT_LO_POS]};

  // Page 3 never matches, so its writes fall away except to the command register
  function automatic logic hit(input logic [1:0] pg,
                               input logic [3:0] off);
    hit = (page == pg) && (s_off == off);
  endfunction

  function automatic logic wr_at(input logic [1:0] pg,
                                 input logic [3:0] off);
    wr_at = wr_start && hit(pg, off);
  endfunction

  // ==========================================================
  // Command register, reachable from every page
  always_ff @(posedge sys_clk_i)
  begin
    if (!reset_n_i)
      command_ff <= pnr_pkg::RESET_BYTE;
    else if (wr_start && s_off == pnr_pkg::OFF_COMMAND)
      command_ff <= s_data;
  end

  // ==========================================================
  // Receive ring pointers
  logic [7:0] ring_first_ff;
  logic [7:0] ring_last_ff;
  logic [7:0] boundary_ff;
  logic [7:0] write_page_ff;
  logic [7:0] next_page;
  logic ring_full;

  always_ff @(posedge sys_clk_i)
  begin
    if (!reset_n_i)
    begin
      ring_first_ff <= pnr_pkg::RESET_BYTE;
      ring_last_ff <= pnr_pkg::RESET_BYTE;
      boundary_ff <= pnr_pkg::RESET_BYTE;
    end
    else
    begin
      if (wr_at(pnr_pkg::PAGE_0, pnr_pkg::OFF_PAGE_LO))
        ring_first_ff <= s_data;
      if (wr_at(pnr_pkg::PAGE_0, pnr_pkg::OFF_PAGE_HI))
        ring_last_ff <= s_data;
      if (wr_at(pnr_pkg::PAGE_0, pnr_pkg::OFF_BOUNDARY))
        boundary_ff <= s_data;
    end
  end

  // Wraps back to the first page when the incremented page equals the last page
  assign next_page = (write_page_ff + 8'h01 == ring_last_ff) ?
                     ring_first_ff : write_page_ff + 8'h01;
  assign ring_full = page_adv_i && (next_page == boundary_ff);

  always_ff @(posedge sys_clk_i)
  begin
    if (!reset_n_i)
      write_page_ff <= pnr_pkg::RESET_BYTE;
    else if (wr_at(pnr_pkg::PAGE_1, pnr_pkg::OFF_WRITE_PAGE))
      write_page_ff <= s_data;
    else if (wr_at(pnr_pkg::PAGE_0, pnr_pkg::OFF_PAGE_LO))
      write_page_ff <= s_data;
    else if (page_adv_i && !ring_full)
      write_page_ff <= next_page;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!reset_n_i)
      local_dma_abort_o <= 1'b0;
    else
      local_dma_abort_o <= ring_full;
  end

  // ==========================================================
  // Transmit and remote DMA setup
  logic [7:0] tx_page_ff;
  logic [15:0] tx_count_ff;
  logic [15:0] rem_start_ff;
  logic [15:0] rem_count_ff;

  always_ff @(posedge sys_clk_i)
  begin
    if (!reset_n_i)
    begin
      tx_page_ff <= pnr_pkg::RESET_BYTE;
      tx_count_ff <= {pnr_pkg::RESET_BYTE, pnr_pkg::RESET_BYTE};
      rem_start_ff <= {pnr_pkg::RESET_BYTE, pnr_pkg::RESET_BYTE};
      rem_count_ff <= {pnr_pkg::RESET_BYTE, pnr_pkg::RESET_BYTE};
    end
    else
    begin
      if (wr_at(pnr_pkg::PAGE_0, pnr_pkg::OFF_TX_PAGE))
        tx_page_ff <= s_data;
      if (wr_at(pnr_pkg::PAGE_0, pnr_pkg::OFF_TX_COUNT_LO))
        tx_count_ff[7:0] <= s_data;
      if (wr_at(pnr_pkg::PAGE_0, pnr_pkg::OFF_TX_COUNT_HI))
        tx_count_ff[15:8] <= s_data;
      if (wr_at(pnr_pkg::PAGE_0, pnr_pkg::OFF_REMOTE_LO))
        rem_start_ff[7:0] <= s_data;
      if (wr_at(pnr_pkg::PAGE_0, pnr_pkg::OFF_REMOTE_HI))
        rem_start_ff[15:8] <= s_data;
      if (wr_at(pnr_pkg::PAGE_0, pnr_pkg::OFF_REM_COUNT_LO))
        rem_count_ff[7:0] <= s_data;
      if (wr_at(pnr_pkg::PAGE_0, pnr_pkg::OFF_REM_COUNT_HI))
        rem_count_ff[15:8] <= s_data;
    end
  end

  // ==========================================================
  // Local DMA address
  logic [15:0] local_addr_ff;

  // Transmit start beats a host write in the same cycle
  always_ff @(posedge sys_clk_i)
  begin
    if (!reset_n_i)
      local_addr_ff <= {pnr_pkg::RESET_BYTE, pnr_pkg::RESET_BYTE};
    else if (tx_start_i)
      local_addr_ff <= {tx_page_ff, pnr_pkg::TX_LOW_ADDR};
    else if (local_addr_ld_i)
      local_addr_ff <= local_addr_i;
    else
    begin
      if (wr_at(pnr_pkg::PAGE_2, pnr_pkg::OFF_PAGE_LO))
        local_addr_ff[7:0] <= s_data;
      if (wr_at(pnr_pkg::PAGE_2, pnr_pkg::OFF_PAGE_HI))
        local_addr_ff[15:8] <= s_data;
    end
  end

  // ==========================================================
  // Configuration, mask and interrupt status
  logic [7:0] rx_cfg_ff;
  logic [7:0] tx_cfg_ff;
  logic [7:0] data_cfg_ff;
  logic [7:0] int_mask_ff;
  logic [7:0] int_status_ff;
  logic [7:0] int_clear;
  logic [7:0] int_set;

  always_ff @(posedge sys_clk_i)
  begin
    if (!reset_n_i)
    begin
      rx_cfg_ff <= pnr_pkg::RESET_BYTE;
      tx_cfg_ff <= pnr_pkg::RESET_BYTE;
      data_cfg_ff <= pnr_pkg::RESET_BYTE;
      int_mask_ff <= pnr_pkg::RESET_BYTE;
    end
    else
    begin
      if (wr_at(pnr_pkg::PAGE_0, pnr_pkg::OFF_RX_CFG))
        rx_cfg_ff <= s_data;
      if (wr_at(pnr_pkg::PAGE_0, pnr_pkg::OFF_TX_CFG))
        tx_cfg_ff <= s_data;
      if (wr_at(pnr_pkg::PAGE_0, pnr_pkg::OFF_DATA_CFG))
        data_cfg_ff <= s_data;
      if (wr_at(pnr_pkg::PAGE_0, pnr_pkg::OFF_INT_MASK))
        int_mask_ff <= s_data;
    end
  end

  // Writing a one clears; a new event in the same cycle survives
  assign int_clear = wr_at(pnr_pkg::PAGE_0, pnr_pkg::OFF_INT_STATUS) ?
                     s_data : 8'h00;
  assign int_set = int_event_i |
                   (8'(ring_full) << pnr_pkg::RING_OVERFLOW_POS);

  always_ff @(posedge sys_clk_i)
  begin
    if (!reset_n_i)
      int_status_ff <= pnr_pkg::RESET_BYTE;
    else
      int_status_ff <= (int_status_ff & ~int_clear) | int_set;
  end

  // ==========================================================
  // Station address and multicast hash bytes
  logic [7:0] station_ff [pnr_pkg::STATION_BYTES];
  logic [7:0] hash_ff [pnr_pkg::HASH_BYTES];

  for (genvar gi = 0; gi < pnr_pkg::STATION_BYTES; gi++)
  begin : g_station
    always_ff @(posedge sys_clk_i)
    begin
      if (!reset_n_i)
        station_ff[gi] <= pnr_pkg::RESET_BYTE;
      else if (wr_at(pnr_pkg::PAGE_1,
                     pnr_pkg::OFF_STATION_BASE + 4'(gi)))
        station_ff[gi] <= s_data;
    end
    assign cfg_o.station_addr[8*gi +: 8] = station_ff[gi];
  end

  for (genvar gi = 0; gi < pnr_pkg::HASH_BYTES; gi++)
  begin : g_hash
    always_ff @(posedge sys_clk_i)
    begin
      if (!reset_n_i)
        hash_ff[gi] <= pnr_pkg::RESET_BYTE;
      else if (wr_at(pnr_pkg::PAGE_1, pnr_pkg::OFF_HASH_BASE + 4'(gi)))
        hash_ff[gi] <= s_data;
    end
    assign cfg_o.multicast_hash[8*gi +: 8] = hash_ff[gi];
  end

  // ==========================================================
  // Diagnostic pointers and address counter
  logic [7:0] rem_next_ff;
  logic [7:0] loc_next_ff;
  logic [7:0] cnt_upper_ff;
  logic [7:0] cnt_lower_ff;

  always_ff @(posedge sys_clk_i)
  begin
    if (!reset_n_i)
    begin
      rem_next_ff <= pnr_pkg::RESET_BYTE;
      loc_next_ff <= pnr_pkg::RESET_BYTE;
      cnt_upper_ff <= pnr_pkg::RESET_BYTE;
      cnt_lower_ff <= pnr_pkg::RESET_BYTE;
    end
    else
    begin
      if (wr_at(pnr_pkg::PAGE_2, pnr_pkg::OFF_REMOTE_NEXT))
        rem_next_ff <= s_data;
      if (wr_at(pnr_pkg::PAGE_2, pnr_pkg::OFF_LOCAL_NEXT))
        loc_next_ff <= s_data;
      if (wr_at(pnr_pkg::PAGE_2, pnr_pkg::OFF_CNT_UPPER))
        cnt_upper_ff <= s_data;
      if (wr_at(pnr_pkg::PAGE_2, pnr_pkg::OFF_CNT_LOWER))
        cnt_lower_ff <= s_data;
    end
  end

  // ==========================================================
  // Read multiplexer
  logic [7:0] rd_mux;

  always_comb
  begin
    rd_mux = 8'h00;
    if (s_off == pnr_pkg::OFF_COMMAND)
      rd_mux = command_ff;
    else
    begin
      case (page)
        pnr_pkg::PAGE_0:
        begin
          case (s_off)
            4'h1: rd_mux = local_addr_ff[7:0];
            4'h2: rd_mux = local_addr_ff[15:8];
            4'h3: rd_mux = boundary_ff;
            4'h4: rd_mux = core_stat_i.tx_status;
            4'h5: rd_mux = core_stat_i.collision_count;
            4'h6: rd_mux = core_stat_i.loopback_byte;
            4'h7: rd_mux = int_status_ff;
            4'h8: rd_mux = core_stat_i.remote_current_addr[7:0];
            4'h9: rd_mux = core_stat_i.remote_current_addr[15:8];
            4'hC: rd_mux = core_stat_i.receive_status;
            4'hD: rd_mux = core_stat_i.frame_align_err_tally;
            4'hE: rd_mux = core_stat_i.checksum_err_tally;
            4'hF: rd_mux = core_stat_i.missed_packet_tally;
            default: rd_mux = 8'h00;
          endcase
        end
        pnr_pkg::PAGE_1:
        begin
          if (s_off == pnr_pkg::OFF_WRITE_PAGE)
            rd_mux = write_page_ff;
          else if (s_off >= pnr_pkg::OFF_HASH_BASE)
            rd_mux = hash_ff[3'(s_off - pnr_pkg::OFF_HASH_BASE)];
          else
            rd_mux = station_ff[3'(s_off - pnr_pkg::OFF_STATION_BASE)];
        end
        pnr_pkg::PAGE_2:
        begin
          case (s_off)
            4'h1: rd_mux = ring_first_ff;
            4'h2: rd_mux = ring_last_ff;
            4'h3: rd_mux = rem_next_ff;
            4'h4: rd_mux = tx_page_ff;
            4'h5: rd_mux = loc_next_ff;
            4'h6: rd_mux = cnt_upper_ff;
            4'h7: rd_mux = cnt_lower_ff;
            4'hC: rd_mux = rx_cfg_ff;
            4'hD: rd_mux = tx_cfg_ff;
            4'hE: rd_mux = data_cfg_ff;
            4'hF: rd_mux = int_mask_ff;
            default: rd_mux = 8'h00;
          endcase
        end
        default: rd_mux = 8'h00;
      endcase
    end
  end

  // ==========================================================
  // Host data drive and loopback pointer advance
  always_ff @(posedge sys_clk_i)
  begin
    if (!reset_n_i)
    begin
      host_data_o <= 8'h00;
      host_data_oe_o <= 1'b0;
      loopback_pop_o <= 1'b0;
    end
    else
    begin
      if (rd_start)
        host_data_o <= rd_mux;
      host_data_oe_o <= !s_rd_n;
      // Only this read location advances anything
      loopback_pop_o <= rd_start &&
                        hit(pnr_pkg::PAGE_0, pnr_pkg::OFF_TX_COUNT_HI);
    end
  end

  // ==========================================================
  // Register outputs to the core
  assign cfg_o.command_reg = command_ff;
  assign cfg_o.rx_ring_first_page = ring_first_ff;
  assign cfg_o.rx_ring_last_page = ring_last_ff;
  assign cfg_o.rx_boundary_pointer = boundary_ff;
  assign cfg_o.rx_write_page = write_page_ff;
  assign cfg_o.tx_page_start = tx_page_ff;
  assign cfg_o.tx_byte_count = tx_count_ff;
  assign cfg_o.remote_start_addr = rem_start_ff;
  assign cfg_o.remote_byte_count = rem_count_ff;
  assign cfg_o.local_current_addr = local_addr_ff;
  assign cfg_o.receive_config = rx_cfg_ff;
  assign cfg_o.transmit_config = tx_cfg_ff;
  assign cfg_o.data_config = data_cfg_ff;
  assign cfg_o.interrupt_mask = int_mask_ff;
  assign cfg_o.interrupt_status = int_status_ff;
  assign cfg_o.remote_next_packet_ptr = rem_next_ff;
  assign cfg_o.local_next_packet_ptr = loc_next_ff;
  assign cfg_o.addr_counter_upper = cnt_upper_ff;
  assign cfg_o.addr_counter_lower = cnt_lower_ff;

endmodule
`default_nettype wire

// ==== design/pnr_pkg.sv ====
// Constants, layouts and carriers of the paged register map
// What this block does
// - Four-bit offset selects sixteen locations per page chosen by two page bits
// - Page 0 offsets 1,2 read local address, write ring first/last page
// - Page 0 offsets 4-6 read tx status/collisions/loopback, write tx page/count
// - Page 0 offset 3 is boundary, offset 7 interrupt status, both ways
// - Page 0 offsets 8,9 read remote current address, A,B read zero; 8-B write remote start/count
// - Page 0 offsets C-F read rx status/tallies, write configs and mask
// - Page 1 holds station bytes, write page and hash bytes, all read/write
// - Page 2 reads ring pages, tx page, configs; writes local address
// - Page 2 offsets 3,5,6,7 are next pointers and counters; 8-B reserved
// - Sixteen-bit registers appear as two separately addressed byte halves
// - Page pointers hold only address bits 15 to 8
// - Transmit start loads local address high from tx page, low cleared
// - Ring first, last, write page and boundary supervise the receive ring
// - Next page equal to boundary aborts local DMA and sets status bit
// - Write page loads with ring first page; host also writes it at page 1 offset 7
package pnr_pkg;

  // ==========================================================
  // Pages, command register fields and interrupt status bit
  localparam logic [1:0] PAGE_0 = 2'h0;
  localparam logic [1:0] PAGE_1 = 2'h1;
  localparam logic [1:0] PAGE_2 = 2'h2;
  localparam int PAGE_SELECT_HI_POS = 7;
  localparam int PAGE_SELECT_LO_POS = 6;
  localparam int RING_OVERFLOW_POS = 4;

  // ==========================================================
  // Offsets
  localparam logic [3:0] OFF_COMMAND = 4'h0;
  localparam logic [3:0] OFF_PAGE_LO = 4'h1;
  localparam logic [3:0] OFF_PAGE_HI = 4'h2;
  localparam logic [3:0] OFF_BOUNDARY = 4'h3;
  localparam logic [3:0] OFF_TX_PAGE = 4'h4;
  localparam logic [3:0] OFF_TX_COUNT_LO = 4'h5;
  localparam logic [3:0] OFF_TX_COUNT_HI = 4'h6;
  localparam logic [3:0] OFF_INT_STATUS = 4'h7;
  localparam logic [3:0] OFF_REMOTE_LO = 4'h8;
  localparam logic [3:0] OFF_REMOTE_HI = 4'h9;
  localparam logic [3:0] OFF_REM_COUNT_LO = 4'hA;
  localparam logic [3:0] OFF_REM_COUNT_HI = 4'hB;
  localparam logic [3:0] OFF_RX_CFG = 4'hC;
  localparam logic [3:0] OFF_TX_CFG = 4'hD;
  localparam logic [3:0] OFF_DATA_CFG = 4'hE;
  localparam logic [3:0] OFF_INT_MASK = 4'hF;
  localparam logic [3:0] OFF_STATION_BASE = 4'h1;
  localparam logic [3:0] OFF_WRITE_PAGE = 4'h7;
  localparam logic [3:0] OFF_HASH_BASE = 4'h8;
  localparam logic [3:0] OFF_REMOTE_NEXT = 4'h3;
  localparam logic [3:0] OFF_LOCAL_NEXT = 4'h5;
  localparam logic [3:0] OFF_CNT_UPPER = 4'h6;
  localparam logic [3:0] OFF_CNT_LOWER = 4'h7;

  // ==========================================================
  // Reset values and counts
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] TX_LOW_ADDR = 8'h00;
  localparam int STATION_BYTES = 6;
  localparam int HASH_BYTES = 8;
  localparam int SYNC_STAGES = 2;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic [7:0] tx_status;
    logic [7:0] collision_count;
    logic [7:0] loopback_byte;
    logic [7:0] receive_status;
    logic [7:0] frame_align_err_tally;
    logic [7:0] checksum_err_tally;
    logic [7:0] missed_packet_tally;
    logic [15:0] remote_current_addr;
  } pnr_core_stat_t;

  typedef struct packed {
    logic [7:0] command_reg;
    logic [7:0] rx_ring_first_page;
    logic [7:0] rx_ring_last_page;
    logic [7:0] rx_boundary_pointer;
    logic [7:0] rx_write_page;
    logic [7:0] tx_page_start;
    logic [15:0] tx_byte_count;
    logic [15:0] remote_start_addr;
    logic [15:0] remote_byte_count;
    logic [15:0] local_current_addr;
    logic [7:0] receive_config;
    logic [7:0] transmit_config;
    logic [7:0] data_config;
    logic [7:0] interrupt_mask;
    logic [7:0] interrupt_status;
    logic [47:0] station_addr;
    logic [63:0] multicast_hash;
    logic [7:0] remote_next_packet_ptr;
    logic [7:0] local_next_packet_ptr;
    logic [7:0] addr_counter_upper;
    logic [7:0] addr_counter_lower;
  } pnr_cfg_t;

endpackage

// ==== design/pnr_sync.sv ====
// Two-stage synchroniser for host pins
`timescale 1ns/100ps
`default_nettype none
module pnr_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  // Data
  input wire logic [WIDTH-1:0] async_i,
  input wire logic [WIDTH-1:0] reset_val_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  // Reset is synchronous, so taking a port value here is legal
  always_ff @(posedge sys_clk_i)
  begin
    if (!reset_n_i)
    begin
      meta_ff <= reset_val_i;
      sync_ff <= reset_val_i;
    end
    else
    begin
      meta_ff <= async_i;
      sync_ff <= meta_ff;
    end
  end

  assign sync_o = sync_ff;

endmodule
`default_nettype wire

// ==== verif/pnr_regmap_monitor.sv ====
// Assertion checker for the paged register map
`timescale 1ns/100ps
`default_nettype none
module pnr_regmap_monitor (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  // Host pins
  input wire logic host_rd_n_i,
  input wire logic host_wr_n_i,
  input wire logic [7:0] host_data_o,
  input wire logic host_data_oe_o,
  // Core side
  input wire logic [7:0] int_event_i,
  input wire logic tx_start_i,
  input wire logic local_addr_ld_i,
  input wire logic [15:0] local_addr_i,
  input wire logic page_adv_i,
  input wire pnr_pkg::pnr_cfg_t cfg_o,
  input wire logic local_dma_abort_o,
  input wire logic loopback_pop_o
);
  logic [7:0] inc_page;
  logic [7:0] nxt_page;
  default clocking mon_cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!reset_n_i);
  // ==========================================================
  // Receive ring
  assign inc_page = cfg_o.rx_write_page + 8'h01;
  assign nxt_page = (inc_page == cfg_o.rx_ring_last_page) ?
    cfg_o.rx_ring_first_page : inc_page;
  ring_full_a: assert property (page_adv_i &&
    nxt_page == cfg_o.rx_boundary_pointer |=> local_dma_abort_o &&
    cfg_o.interrupt_status[pnr_pkg::RING_OVERFLOW_POS] &&
    $stable(cfg_o.rx_write_page)) else $error("full ring not aborted");
  ring_advance_a: assert property (page_adv_i &&
    nxt_page != cfg_o.rx_boundary_pointer |=>
    cfg_o.rx_write_page == $past(nxt_page)) else $error("no page advance");
  // ==========================================================
  // Core loads and events
  tx_load_a: assert property (tx_start_i |=>
    cfg_o.local_current_addr == {$past(cfg_o.tx_page_start), 8'h00})
    else $error("tx start address wrong");
  local_load_a: assert property (local_addr_ld_i && !tx_start_i |=>
    cfg_o.local_current_addr == $past(local_addr_i))
    else $error("local address load wrong");
  event_sticky_a: assert property (|int_event_i |=>
    (cfg_o.interrupt_status & $past(int_event_i)) == $past(int_event_i))
    else $error("event bit not set");
  pop_once_a: assert property (loopback_pop_o |=> !loopback_pop_o)
    else $error("pop longer than a cycle");
  // ==========================================================
  // Host bus
  read_cause_a: assert property ($rose(host_data_oe_o) |->
    !host_rd_n_i && $past(host_rd_n_i, 2) == 1'b0)
    else $error("bus driven without read");
  quiet_cfg_a: assert property (host_wr_n_i && $past(host_wr_n_i) &&
    $past(host_wr_n_i, 2) && $past(host_wr_n_i, 3) |->
    $stable(cfg_o.tx_byte_count) && $stable(cfg_o.remote_byte_count))
    else $error("count changed without write");
  abort_seen_c: cover property (local_dma_abort_o);
  tx_start_c: cover property (tx_start_i);
  read_seen_c: cover property ($rose(host_data_oe_o));
  zero_read_c: cover property ($rose(host_data_oe_o) && host_data_o == 8'h00);
endmodule
bind pnr_regmap pnr_regmap_monitor u_monitor (.sys_clk_i(sys_clk_i),
  .reset_n_i(reset_n_i), .host_rd_n_i(host_rd_n_i),
  .host_wr_n_i(host_wr_n_i), .host_data_o(host_data_o),
  .host_data_oe_o(host_data_oe_o), .int_event_i(int_event_i),
  .tx_start_i(tx_start_i), .local_addr_ld_i(local_addr_ld_i),
  .local_addr_i(local_addr_i), .page_adv_i(page_adv_i), .cfg_o(cfg_o),
  .local_dma_abort_o(local_dma_abort_o), .loopback_pop_o(loopback_pop_o));
`default_nettype wire

// ==== verif/pnr_host_model.sv ====
// Host processor model for the slave register pins
`timescale 1ns/100ps
`default_nettype none
module pnr_host_model (
  // Clock and read data
  input wire logic sys_clk_i,
  input wire logic [7:0] host_data_o,
  // Host pins
  output logic host_rd_n_o,
  output logic host_wr_n_o,
  output logic [3:0] offset_o,
  output logic [7:0] data_o
);
  initial {host_rd_n_o, host_wr_n_o, offset_o, data_o} = 14'h3000;
  // ==========================================================
  // Bus cycles
  // Strobes stay low four cycles and high three or more: the pins pass
  // a two-stage synchroniser, so shorter pulses could be lost
  task automatic wr(input logic [3:0] off, input logic [7:0] val);
    if (off == 4'h0 && val[7:6] == 2'h3)
      return;
    @(negedge sys_clk_i);
    {offset_o, data_o, host_wr_n_o} = {off, val, 1'b0};
    repeat (4) @(negedge sys_clk_i);
    host_wr_n_o = 1'b1;
    repeat (3) @(negedge sys_clk_i);
    // Released bus shows no stale byte
    data_o = ~val;
  endtask
  task automatic rd(input logic [3:0] off, output logic [7:0] val);
    @(negedge sys_clk_i);
    {offset_o, host_rd_n_o} = {off, 1'b0};
    repeat (4) @(negedge sys_clk_i);
    val = host_data_o;
    host_rd_n_o = 1'b1;
    repeat (4) @(negedge sys_clk_i);
  endtask
endmodule
`default_nettype wire

// ==== verif/pnr_regmap_tb_top.sv ====
// Self-checking testbench of the paged register map
`timescale 1ns/100ps
`default_nettype none
module pnr_regmap_tb_top;
  logic sys_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic rd_n, wr_n, oe, abort, pop;
  logic [3:0] offset;
  logic [7:0] wdata, rdata;
  logic [7:0] int_event = 8'h00;
  logic tx_start = 1'b0, ld = 1'b0, adv = 1'b0;
  logic [15:0] laddr = 16'h0000;
  pnr_pkg::pnr_core_stat_t stat = {8'hA1, 8'hA2, 8'hA3, 8'hA4, 8'hA5,
    8'hA6, 8'hA7, 16'hA9A8};
  pnr_pkg::pnr_cfg_t cfg;
  int mismatches = 0, num_checks = 0, pops = 0, aborts = 0, drives = 0;
  always #2 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i)
  begin
    pops <= pops + int'(pop);
    aborts <= aborts + int'(abort);
    drives <= drives + int'(oe);
  end
  pnr_host_model u_host (.sys_clk_i(sys_clk_i), .host_data_o(rdata),
    .host_rd_n_o(rd_n), .host_wr_n_o(wr_n), .offset_o(offset),
    .data_o(wdata));
  pnr_regmap DUT (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
    .host_rd_n_i(rd_n), .host_wr_n_i(wr_n), .register_offset_i(offset),
    .host_data_i(wdata), .host_data_o(rdata), .host_data_oe_o(oe),
    .core_stat_i(stat), .int_event_i(int_event), .tx_start_i(tx_start),
    .local_addr_ld_i(ld), .local_addr_i(laddr), .page_adv_i(adv),
    .cfg_o(cfg), .local_dma_abort_o(abort), .loopback_pop_o(pop));
  // ==========================================================
  // Helpers
  task automatic chk(input string nm, input logic [63:0] seen,
    input logic [63:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic rchk(input logic [3:0] off, input logic [7:0] exp);
    logic [7:0] v;
    u_host.rd(off, v);
    chk($sformatf("read offset %h", off), 64'(v), 64'(exp));
  endtask
  // One-cycle core request: bit 2 tx start, bit 1 load, bit 0 advance
  task automatic core_pulse(input logic [2:0] sel);
    @(negedge sys_clk_i);
    {tx_start, ld, adv} = sel;
    @(negedge sys_clk_i);
    {tx_start, ld, adv} = 3'h0;
    repeat (2) @(negedge sys_clk_i);
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // ==========================================================
  // Scenarios
  task automatic test_page0;
    logic [7:0] e [16] = '{8'h00, 8'h00, 8'h00, 8'h43, 8'hA1, 8'hA2, 8'hA3,
      8'h00, 8'hA8, 8'hA9, 8'h00, 8'h00, 8'hA4, 8'hA5, 8'hA6, 8'hA7};
    for (int i = 1; i < 16; i++)
      u_host.wr(4'(i), 8'(8'h40 + i));
    for (int i = 0; i < 16; i++)
      rchk(4'(i), e[i]);
    chk("tx count", 64'(cfg.tx_byte_count), 64'h4645);
    chk("remote start", 64'(cfg.remote_start_addr), 64'h4948);
    chk("remote count", 64'(cfg.remote_byte_count), 64'h4B4A);
    chk("loopback pops", 64'(pops), 64'h1);
    // Bus is driven four cycles per read, from strobe sync to release
    chk("drive cycles", 64'(drives), 64'h40);
    $display("page 0 test done");
  endtask
  task automatic test_page1;
    u_host.wr(4'h0, 8'h40);
    for (int i = 1; i < 16; i++)
      u_host.wr(4'(i), 8'(8'h60 + i));
    for (int i = 0; i < 16; i++)
      rchk(4'(i), (i == 0) ? 8'h40 : 8'(8'h60 + i));
    chk("station", 64'(cfg.station_addr), 64'h666564636261);
    chk("hash", cfg.multicast_hash, 64'h6F6E6D6C6B6A6968);
    $display("page 1 test done");
  endtask
  task automatic test_page2;
    logic [7:0] e [16] = '{8'h80, 8'h41, 8'h42, 8'hC3, 8'h44, 8'hC5, 8'hC6,
      8'hC7, 8'h00, 8'h00, 8'h00, 8'h00, 8'h4C, 8'h4D, 8'h4E, 8'h4F};
    u_host.wr(4'h0, 8'h80);
    for (int i = 1; i < 16; i++)
      u_host.wr(4'(i), 8'(8'hC0 + i));
    for (int i = 0; i < 16; i++)
      rchk(4'(i), e[i]);
    chk("local addr", 64'(cfg.local_current_addr), 64'hC2C1);
    $display("page 2 test done");
  endtask
  task automatic test_core;
    u_host.wr(4'h0, 8'h00);
    core_pulse(3'h4);
    rchk(4'h1, 8'h00);
    rchk(4'h2, 8'h44);
    laddr = 16'h5A3C;
    core_pulse(3'h2);
    chk("local addr", 64'(cfg.local_current_addr), 64'h5A3C);
    @(negedge sys_clk_i);
    int_event = 8'h81;
    @(negedge sys_clk_i);
    int_event = 8'h00;
    rchk(4'h7, 8'h81);
    u_host.wr(4'h7, 8'h01);
    rchk(4'h7, 8'h80);
    u_host.wr(4'h1, 8'h10);
    u_host.wr(4'h2, 8'h20);
    u_host.wr(4'h3, 8'h12);
    chk("write page", 64'(cfg.rx_write_page), 64'h10);
    core_pulse(3'h1);
    chk("write page", 64'(cfg.rx_write_page), 64'h11);
    core_pulse(3'h1);
    chk("aborts", 64'(aborts), 64'h1);
    chk("write page", 64'(cfg.rx_write_page), 64'h11);
    rchk(4'h7, 8'h90);
    $display("core test done");
  endtask
  // ==========================================================
  // Main sequence and watchdog
  initial
  begin
    repeat (6) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    reset_n_i = 1'b1;
    chk("reset state", 64'({cfg == '0, oe}), 64'h2);
    test_page0();
    test_page1();
    test_page2();
    test_core();
    summarize();
  end
  initial
  begin
    repeat (20000) @(posedge sys_clk_i);
    mismatches++;
    summarize();
  end
endmodule
`default_nettype wire
